// *** design/otp_device.sv ***
`timescale 1ns/1ps
`include "otp_port_regs.svh"
// What this block does
// - programming pins take chip, read, mode roles
// - address counter steps once per clock pulse
// - clear high holds counter at zero
// - read code drives counter byte out
// - program code writes bus byte at counter
// - verify code outputs stored byte
// - protect option code with three high voltages
// - low noise code, chip select high voltage
// - latch disable code, read drive low
// - permanent watchdog code, mode select low
// - lockout code, mode low, read low
// - program strobe low at least 0.95 ms
// - overprogram strobe low at least 2.85 ms
// - option strobe low at least 78 ms
// - protected part refuses external read-out
// - protect never enables low noise itself
// - latch disable turns off all auto latches
// - permanent watchdog runs, cannot be stopped
// - lockout blocks programming after power cycle
// - low noise removes clock divide by two
// - bus output while read drive low, in read and verify codes only
// - memory written only while strobe low
module otp_device #(
  parameter int ADDR_W = 10,
  parameter int DEPTH = 1024
) (
  input wire logic ref_clk,
  input wire logic nrst,
  otp_link_if.device link,
  output logic [7:0] read_byte,
  output logic latch_disable,
  output logic wdt_permanent,
  output logic wdt_stoppable,
  output logic system_timer_clock,
  output logic low_noise_mode,
  output logic read_protected,
  output logic prog_locked
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] clr_sync;
    logic [1:0] ws_sync;
    otp_port_pkg::level_t cs_meta;
    otp_port_pkg::level_t cs_sync;
    otp_port_pkg::level_t mode_meta;
    otp_port_pkg::level_t mode_sync;
    otp_port_pkg::level_t vpp_meta;
    otp_port_pkg::level_t vpp_sync;
    logic [1:0] rd_sync;
    logic clk_last;
    logic [ADDR_W-1:0] addr;
    otp_port_pkg::options_t opt;
    logic lock_live;
    logic [7:0] dout;
    logic oe_n;
    logic div;
    logic sys_clk;
  } state_t;

  // fuses read blank at power-up; reset leaves them alone
  state_t st_reg = '0;
  state_t st_next;
  logic [7:0] mem [DEPTH];
  logic mem_we;
  otp_port_pkg::op_t op;
  logic op_ok;

  // ------------------------------------------------------------
  // operation decode from pin levels
  // ------------------------------------------------------------
  function automatic logic decode(
    input otp_port_pkg::level_t vpp,
    input otp_port_pkg::level_t prog_mode_select,
    input otp_port_pkg::level_t ce,
    input logic oe_n,
    input logic pgm_n,
    output otp_port_pkg::op_t o
  );
    decode = 1'b1;
    o = otp_port_pkg::OP_READ;
    if (prog_mode_select == otp_port_pkg::LVL_HV && ce == otp_port_pkg::LVL_HV &&
        vpp == otp_port_pkg::LVL_HV && oe_n && !pgm_n) begin
      o = otp_port_pkg::OP_PROTECT;
    end else if (prog_mode_select == otp_port_pkg::LVL_HV &&
                 ce == otp_port_pkg::LVL_LOW && !oe_n && pgm_n) begin
      o = otp_port_pkg::OP_READ;
    end else if (vpp != otp_port_pkg::LVL_HV) begin
      decode = 1'b0;
    end else if (ce == otp_port_pkg::LVL_LOW &&
                 prog_mode_select == otp_port_pkg::LVL_HIGH) begin
      if (oe_n && !pgm_n) o = otp_port_pkg::OP_PROGRAM;
      else if (!oe_n && pgm_n) o = otp_port_pkg::OP_VERIFY;
      else decode = 1'b0;
    end else if (ce == otp_port_pkg::LVL_HV && !pgm_n &&
                 prog_mode_select == otp_port_pkg::LVL_HIGH) begin
      o = oe_n ? otp_port_pkg::OP_LOW_NOISE
               : otp_port_pkg::OP_LATCH_OFF;
    end else if (ce == otp_port_pkg::LVL_HV && !pgm_n &&
                 prog_mode_select == otp_port_pkg::LVL_LOW) begin
      o = oe_n ? otp_port_pkg::OP_WDT_PERM
               : otp_port_pkg::OP_LOCKOUT;
    end else begin
      decode = 1'b0;
    end
  endfunction

  // programmer pins are asynchronous to the core: two flops on each control pin, none on data_from_host
  always_comb begin
    op_ok = decode(st_reg.vpp_sync, st_reg.mode_sync,
                   st_reg.cs_sync, st_reg.rd_sync[1],
                   st_reg.ws_sync[1], op);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    mem_we = 1'b0;
    st_next.clk_sync = {st_reg.clk_sync[0], link.addr_clock};
    st_next.clr_sync = {st_reg.clr_sync[0], link.addr_clear};
    st_next.ws_sync = {st_reg.ws_sync[0], link.write_strobe_n};
    st_next.cs_meta = link.chip_select;
    st_next.cs_sync = st_reg.cs_meta;
    st_next.mode_meta = link.mode_select;
    st_next.mode_sync = st_reg.mode_meta;
    st_next.vpp_meta = link.program_supply;
    st_next.vpp_sync = st_reg.vpp_meta;
    st_next.rd_sync = {st_reg.rd_sync[0], link.read_drive_n};
    st_next.clk_last = st_reg.clk_sync[1];
    if (st_reg.clr_sync[1]) begin
      st_next.addr = '0;
    end else if (st_reg.clk_sync[1] && !st_reg.clk_last) begin
      st_next.addr = st_reg.addr + 1'b1;
    end
    st_next.oe_n = 1'b1;
    // lockout acts from power-up only, hence lock_live sampled at reset
    if (op_ok && !st_reg.lock_live) begin
      unique case (op)
        otp_port_pkg::OP_READ, otp_port_pkg::OP_VERIFY: begin
          if (!st_reg.opt.protect) begin
            st_next.oe_n = 1'b0;
            st_next.dout = mem[st_reg.addr];
          end
        end
        otp_port_pkg::OP_PROGRAM: mem_we = 1'b1;
        otp_port_pkg::OP_PROTECT: st_next.opt.protect = 1'b1;
        otp_port_pkg::OP_LOW_NOISE: st_next.opt.low_noise = 1'b1;
        otp_port_pkg::OP_LATCH_OFF: st_next.opt.latch_off = 1'b1;
        otp_port_pkg::OP_WDT_PERM: st_next.opt.wdt_perm = 1'b1;
        otp_port_pkg::OP_LOCKOUT: st_next.opt.lockout = 1'b1;
      endcase
    end
    // low noise toggles every cycle (half the oscillator), else halve it again
    st_next.div = ~st_reg.div;
    st_next.sys_clk = st_reg.opt.low_noise ? ~st_reg.sys_clk
                                           : st_reg.sys_clk ^ st_reg.div;
  end

  // ------------------------------------------------------------
  // registers; option bits survive reset like fuses
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg.clk_sync <= 2'h0;
      st_reg.clr_sync <= 2'h0;
      st_reg.ws_sync <= 2'h3;
      st_reg.cs_meta <= otp_port_pkg::LVL_HIGH;
      st_reg.cs_sync <= otp_port_pkg::LVL_HIGH;
      st_reg.mode_meta <= otp_port_pkg::LVL_HIGH;
      st_reg.mode_sync <= otp_port_pkg::LVL_HIGH;
      st_reg.vpp_meta <= otp_port_pkg::LVL_HIGH;
      st_reg.vpp_sync <= otp_port_pkg::LVL_HIGH;
      st_reg.rd_sync <= 2'h3;
      st_reg.clk_last <= 1'b0;
      st_reg.addr <= '0;
      st_reg.lock_live <= st_reg.opt.lockout;
      st_reg.dout <= 8'h00;
      st_reg.oe_n <= 1'b1;
      st_reg.div <= 1'b0;
      st_reg.sys_clk <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[st_reg.addr] <= link.data_from_host;
    end
  end

  // ------------------------------------------------------------
  // pins and option outputs
  // ------------------------------------------------------------

  assign link.data_from_dev = st_reg.dout;
  assign link.data_dev_oe_n = st_reg.oe_n;
  assign read_byte = st_reg.dout;
  assign latch_disable = st_reg.opt.latch_off;
  assign wdt_permanent = st_reg.opt.wdt_perm;
  assign wdt_stoppable = ~st_reg.opt.wdt_perm;
  assign system_timer_clock = st_reg.sys_clk;
  assign low_noise_mode = st_reg.opt.low_noise;
  assign read_protected = st_reg.opt.protect;
  assign prog_locked = st_reg.lock_live;
endmodule

// *** design/otp_link_if.sv ***
`timescale 1ns/1ps
interface otp_link_if;
  otp_port_pkg::level_t chip_select;
  logic read_drive_n;
  otp_port_pkg::level_t mode_select;
  otp_port_pkg::level_t program_supply;
  logic write_strobe_n;
  logic addr_clock;
  logic addr_clear;
  logic [7:0] data_from_host;
  logic data_host_oe_n;
  logic [7:0] data_from_dev;
  logic data_dev_oe_n;
  logic [7:0] data_bus;

  // bus level resolved from both enables
  assign data_bus = !data_dev_oe_n ? data_from_dev :
                    !data_host_oe_n ? data_from_host : 8'hff;

  modport device (
    input chip_select, read_drive_n, mode_select, program_supply,
    input write_strobe_n, addr_clock, addr_clear, data_from_host,
    input data_host_oe_n,
    output data_from_dev, data_dev_oe_n
  );
  modport host (
    output chip_select, read_drive_n, mode_select, program_supply,
    output write_strobe_n, addr_clock, addr_clear, data_from_host,
    output data_host_oe_n,
    input data_from_dev, data_dev_oe_n
  );
endinterface

// *** design/otp_port_pkg.sv ***
package otp_port_pkg;

  // supply / select pin levels: low, high, high-voltage
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_HV = 2'h2
  } level_t;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_VERIFY = 3'h2,
    OP_PROTECT = 3'h3,
    OP_LOW_NOISE = 3'h4,
    OP_LATCH_OFF = 3'h5,
    OP_WDT_PERM = 3'h6,
    OP_LOCKOUT = 3'h7
  } op_t;

  typedef struct packed {
    logic protect;
    logic low_noise;
    logic latch_off;
    logic wdt_perm;
    logic lockout;
  } options_t;

endpackage

// *** design/otp_port_regs.svh ***
`ifndef OTP_PORT_REGS_SVH
`define OTP_PORT_REGS_SVH

// ------------------------------------------------------------
// controller register byte offsets
// ------------------------------------------------------------
`define OTP_CTRL_OFS 8'h00
`define OTP_DATA_OFS 8'h04
`define OTP_STAT_OFS 8'h08
`define OTP_PULSE_OFS 8'h0c

// ------------------------------------------------------------
// control and status register fields
// ------------------------------------------------------------
`define OTP_CTRL_GO_BIT 0
`define OTP_CTRL_OP_LSB 4
`define OTP_CTRL_OP_MSB 6
`define OTP_STAT_BUSY_BIT 8
`define OTP_STAT_PROT_BIT 9

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OTP_CLK_NS 10
`define OTP_PROG_PULSE_US 950
`define OTP_OVER_PULSE_US 2850
`define OTP_OPT_PULSE_MS 78
`define OTP_PROG_PULSE_CYC (`OTP_PROG_PULSE_US * 1000 / `OTP_CLK_NS)
`define OTP_OVER_PULSE_CYC (`OTP_OVER_PULSE_US * 1000 / `OTP_CLK_NS)
`define OTP_OPT_PULSE_CYC (`OTP_OPT_PULSE_MS * 1000000 / `OTP_CLK_NS)
`define OTP_SETUP_US 2
`define OTP_SETUP_CYC (`OTP_SETUP_US * 1000 / `OTP_CLK_NS)
`define OTP_LINK_HALF 6

`endif

// *** design/otp_programmer.sv ***
`timescale 1ns/1ps
`include "otp_port_regs.svh"
module otp_programmer #(
  parameter int PROG_CYC = `OTP_PROG_PULSE_CYC,
  parameter int OVER_CYC = `OTP_OVER_PULSE_CYC,
  parameter int OPT_CYC = `OTP_OPT_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  otp_link_if.host link,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ------------------------------------------------------------
  // sequencer: set levels, clock address, pulse strobe
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_SETUP = 3'h1, S_PULSE = 3'h3,
    S_HOLD = 3'h2, S_CLK = 3'h6
  } seq_t;

  typedef struct packed {
    seq_t seq;
    otp_port_pkg::op_t op;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [31:0] cnt;
    logic [31:0] pulse_len;
    logic clear_req;
    logic step_req;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_ofs;
    logic [31:0] wd;
    logic bv;
    logic rv;
    logic [31:0] rd;
    logic [1:0] din_sync;
    logic [7:0] d0;
    logic [7:0] d1;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic busy;

  function automatic logic [31:0] pulse_for(
    input otp_port_pkg::op_t o,
    input logic over
  );
    if (o == otp_port_pkg::OP_PROGRAM)
      pulse_for = over ? 32'(OVER_CYC) : 32'(PROG_CYC);
    else
      pulse_for = 32'(OPT_CYC);
  endfunction

  assign busy = st_reg.seq != S_IDLE;
  assign awready = !st_reg.aw_got && !st_reg.bv;
  assign wready = !st_reg.w_got && !st_reg.bv;
  assign arready = !st_reg.rv;

  always_comb begin
    st_next = st_reg;
    st_next.d0 = link.data_from_dev;
    st_next.d1 = st_reg.d0;
    st_next.din_sync = {st_reg.din_sync[0], link.data_dev_oe_n};
    if (awvalid && awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_ofs = awaddr[7:0];
    end
    if (wvalid && wready) begin
      st_next.w_got = 1'b1;
      st_next.wd = wdata;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bv = 1'b1;
      if (st_reg.aw_ofs == `OTP_CTRL_OFS && !busy) begin
        if (st_reg.wd[1]) st_next.clear_req = 1'b1;
        if (st_reg.wd[2]) st_next.step_req = 1'b1;
        if (st_reg.wd[`OTP_CTRL_GO_BIT]) begin
          st_next.op = otp_port_pkg::op_t'(
            st_reg.wd[`OTP_CTRL_OP_MSB:`OTP_CTRL_OP_LSB]);
          st_next.pulse_len = pulse_for(otp_port_pkg::op_t'(
            st_reg.wd[`OTP_CTRL_OP_MSB:`OTP_CTRL_OP_LSB]), st_reg.wd[3]);
          st_next.seq = S_SETUP;
          st_next.cnt = 32'(`OTP_SETUP_CYC);
        end
      end else if (st_reg.aw_ofs == `OTP_DATA_OFS) begin
        st_next.wbyte = st_reg.wd[7:0];
      end
    end
    if (st_reg.bv && bready) st_next.bv = 1'b0;
    if (arvalid && arready) begin
      st_next.rv = 1'b1;
      unique case (araddr[7:0])
        `OTP_DATA_OFS: st_next.rd = {24'h0, st_reg.rbyte};
        `OTP_STAT_OFS: st_next.rd = {23'h0, busy, st_reg.rbyte};
        `OTP_CTRL_OFS: st_next.rd = {29'h0, st_reg.op};
        default: st_next.rd = 32'h0;
      endcase
    end
    if (st_reg.rv && rready) st_next.rv = 1'b0;
    unique case (st_reg.seq)
      S_IDLE: begin
        if (st_reg.step_req || st_reg.clear_req) begin
          st_next.seq = S_CLK;
          st_next.cnt = 32'(`OTP_LINK_HALF * 2);
        end
      end
      S_SETUP: begin
        st_next.cnt = st_reg.cnt - 32'h1;
        if (st_reg.cnt == 32'h0) begin
          st_next.seq = S_PULSE;
          st_next.cnt = st_reg.pulse_len;
        end
      end
      S_PULSE: begin
        st_next.cnt = st_reg.cnt - 32'h1;
        if (st_reg.cnt == 32'h0) begin
          st_next.seq = S_HOLD;
          st_next.cnt = 32'(`OTP_SETUP_CYC);
          // undriven bus floats to its pull-up level
          st_next.rbyte = st_reg.din_sync[1] ? 8'hff : st_reg.d1;
        end
      end
      S_HOLD: begin
        st_next.cnt = st_reg.cnt - 32'h1;
        if (st_reg.cnt == 32'h0) st_next.seq = S_IDLE;
      end
      S_CLK: begin
        st_next.cnt = st_reg.cnt - 32'h1;
        if (st_reg.cnt == 32'h0) begin
          st_next.seq = S_IDLE;
          // the request flag selects the pin, so drop it only here
          if (st_reg.clear_req) st_next.clear_req = 1'b0;
          else st_next.step_req = 1'b0;
        end
      end
      default: st_next.seq = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) st_reg <= '0;
    else st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // pin levels per operation
  // ------------------------------------------------------------
  logic writes;
  logic reads;
  assign writes = st_reg.op != otp_port_pkg::OP_READ &&
                  st_reg.op != otp_port_pkg::OP_VERIFY;
  assign reads = !writes ||
                 st_reg.op inside {otp_port_pkg::OP_LATCH_OFF,
                                   otp_port_pkg::OP_LOCKOUT};
  always_comb begin
    link.program_supply = busy && st_reg.op != otp_port_pkg::OP_READ ?
      otp_port_pkg::LVL_HV : otp_port_pkg::LVL_HIGH;
    link.mode_select = st_reg.op inside {otp_port_pkg::OP_READ,
      otp_port_pkg::OP_PROTECT} ? otp_port_pkg::LVL_HV :
      st_reg.op inside {otp_port_pkg::OP_WDT_PERM,
      otp_port_pkg::OP_LOCKOUT} ? otp_port_pkg::LVL_LOW :
      otp_port_pkg::LVL_HIGH;
    link.chip_select = !busy ? otp_port_pkg::LVL_HIGH :
      (st_reg.op inside {otp_port_pkg::OP_READ, otp_port_pkg::OP_PROGRAM,
       otp_port_pkg::OP_VERIFY}) ? otp_port_pkg::LVL_LOW :
      otp_port_pkg::LVL_HV;
  end
  assign link.read_drive_n = !(busy && reads);
  // strobe only in pulse phase; pulse length per op
  assign link.write_strobe_n = !(st_reg.seq == S_PULSE && writes);
  assign link.data_from_host = st_reg.wbyte;
  assign link.data_host_oe_n = !(busy && st_reg.op ==
                                 otp_port_pkg::OP_PROGRAM);
  assign link.addr_clock = st_reg.seq == S_CLK && !st_reg.clear_req &&
                           st_reg.cnt >= 32'(`OTP_LINK_HALF);
  assign link.addr_clear = st_reg.seq == S_CLK && st_reg.clear_req;
  assign bresp = 2'h0;
  assign bvalid = st_reg.bv;
  assign rdata = st_reg.rd;
  assign rresp = 2'h0;
  assign rvalid = st_reg.rv;
endmodule

// *** verification/otp_port_chk.sv ***
`timescale 1ns/1ps
`include "otp_port_regs.svh"
module otp_port_chk #(
  parameter int PROG_CYC = `OTP_PROG_PULSE_CYC,
  parameter int OPT_CYC = `OTP_OPT_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire otp_port_pkg::level_t chip_select,
  input wire logic read_drive_n,
  input wire otp_port_pkg::level_t mode_select,
  input wire otp_port_pkg::level_t program_supply,
  input wire logic write_strobe_n,
  input wire logic addr_clock,
  input wire logic addr_clear,
  input wire logic [7:0] data_from_host,
  input wire logic data_host_oe_n,
  input wire logic data_dev_oe_n
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // up_reg masks the first edges, where $past still sees reset values
  logic [1:0] up_reg;
  logic [31:0] lcnt_reg;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      up_reg <= 2'h0;
      lcnt_reg <= 32'h0;
    end else begin
      if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
      lcnt_reg <= write_strobe_n ? 32'h0 : lcnt_reg + 32'h1;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || up_reg != 2'h3);
  sequence strobe_held;
    !write_strobe_n ##1 !write_strobe_n;
  endsequence
  // device samples pins through two flops, so allow it settling time
  sequence rd_high;
    read_drive_n [*4];
  endsequence
  sequence cs_off;
    (chip_select != otp_port_pkg::LVL_LOW) [*4];
  endsequence

  chk_bus_release: assert property (rd_high |-> data_dev_oe_n)
    else $error("device drives bus with read drive high");
  chk_host_dir: assert property (!data_host_oe_n |-> read_drive_n)
    else $error("host drives bus with read drive low");
  chk_no_fight: assert property (!data_host_oe_n |-> data_dev_oe_n)
    else $error("both ends drive the data bus");
  chk_out_select: assert property (cs_off |-> data_dev_oe_n)
    else $error("device drives bus without chip select");
  chk_prog_code: assert property (
    !write_strobe_n && chip_select == otp_port_pkg::LVL_LOW |->
      program_supply == otp_port_pkg::LVL_HV &&
      mode_select == otp_port_pkg::LVL_HIGH && read_drive_n)
    else $error("program strobe with wrong pin levels");
  chk_opt_supply: assert property (
    !write_strobe_n && chip_select == otp_port_pkg::LVL_HV |->
      program_supply == otp_port_pkg::LVL_HV)
    else $error("option strobe without program supply");
  chk_strobe_hold: assert property (strobe_held |->
    $stable(chip_select) && $stable(mode_select) &&
    $stable(read_drive_n) && $stable(data_from_host))
    else $error("pins change while strobe low");
  chk_addr_fixed: assert property (!write_strobe_n |->
    !$rose(addr_clock) && !addr_clear)
    else $error("address moves while strobe low");
  chk_prog_width: assert property ($rose(write_strobe_n) &&
    $past(program_supply) == otp_port_pkg::LVL_HV &&
    $past(chip_select) == otp_port_pkg::LVL_LOW |->
      lcnt_reg >= PROG_CYC)
    else $error("program pulse too short");
  chk_opt_width: assert property ($rose(write_strobe_n) &&
    $past(chip_select) == otp_port_pkg::LVL_HV |->
      lcnt_reg >= OPT_CYC)
    else $error("option pulse too short");
endmodule

// *** verification/otp_programming_port_bench.sv ***
`timescale 1ns/1ps
`include "otp_port_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module otp_programming_port_bench;
  localparam int PC = 50;
  localparam int OC = 60;
  localparam int XC = 80;
  logic ref_clk, nrst;
  logic [31:0] awaddr, wdata, araddr, rdata, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [7:0] read_byte;
  logic latch_disable, wdt_permanent, wdt_stoppable, system_timer_clock;
  logic low_noise_mode, read_protected, prog_locked;
  logic [7:0] mem [4];
  int failures, n_tests, seed, i, c;

  otp_link_if link_if ();
  otp_device otp_device_inst (.ref_clk(ref_clk), .nrst(nrst),
    .link(link_if), .read_byte(read_byte), .latch_disable(latch_disable),
    .wdt_permanent(wdt_permanent), .wdt_stoppable(wdt_stoppable),
    .system_timer_clock(system_timer_clock),
    .low_noise_mode(low_noise_mode), .read_protected(read_protected),
    .prog_locked(prog_locked));
  otp_programmer #(.PROG_CYC(PC), .OVER_CYC(OC), .OPT_CYC(XC))
    otp_programmer_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link_if),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  otp_port_chk #(.PROG_CYC(PC), .OPT_CYC(XC)) otp_port_chk_inst (
    .ref_clk(ref_clk), .nrst(nrst), .chip_select(link_if.chip_select),
    .read_drive_n(link_if.read_drive_n),
    .mode_select(link_if.mode_select),
    .program_supply(link_if.program_supply),
    .write_strobe_n(link_if.write_strobe_n),
    .addr_clock(link_if.addr_clock), .addr_clear(link_if.addr_clear),
    .data_from_host(link_if.data_from_host),
    .data_host_oe_n(link_if.data_host_oe_n),
    .data_dev_oe_n(link_if.data_dev_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_sim;
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task guard(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      end_sim();
    end
  endtask

  task axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        `CHK(bresp, 2'h0)
        break;
      end
    end
    bready <= 1'b0;
    guard(n, 100);
  endtask

  task axi_rd(input logic [31:0] a);
    int n;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rdata;
        `CHK(rresp, 2'h0)
        break;
      end
    end
    rready <= 1'b0;
    guard(n, 100);
  endtask

  // ctrl writes while busy are dropped, so every order waits for idle
  task ctl(input logic [31:0] v);
    int n;
    axi_wr({24'h0, `OTP_CTRL_OFS}, v);
    for (n = 0; n < 500; n++) begin
      axi_rd({24'h0, `OTP_STAT_OFS});
      if (r[`OTP_STAT_BUSY_BIT] === 1'b0) break;
    end
    guard(n, 500);
  endtask

  function automatic logic [31:0] opw(input otp_port_pkg::op_t o,
                                      input logic ov);
    return {25'h0, o, ov, 3'h1};
  endfunction

  function automatic logic [7:0] exp_byte(input logic prot,
                                          input logic [7:0] b);
    return prot ? 8'hff : b;
  endfunction

  task rd_cell(input otp_port_pkg::op_t o, input logic [7:0] e);
    ctl(opw(o, 1'b0));
    axi_rd({24'h0, `OTP_DATA_OFS});
    `CHK(r[7:0], e)
  endtask

  task tgl;
    logic p;
    c = 0;
    @(posedge ref_clk);
    p = system_timer_clock;
    repeat (8) begin
      @(posedge ref_clk);
      if (system_timer_clock !== p) c++;
      p = system_timer_clock;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'he276;
    failures = 0;
    n_tests = 0;
    nrst = 1'b0;
    {awaddr, wdata, araddr} = 96'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    `CHK(link_if.data_dev_oe_n, 1'b1)
    ctl(32'h2);
    for (i = 0; i < 4; i++) begin
      mem[i] = (i == 0) ? 8'h00 : 8'($random(seed));
      axi_wr({24'h0, `OTP_DATA_OFS}, {24'h0, mem[i]});
      ctl(opw(otp_port_pkg::OP_PROGRAM, 1'b0));
      rd_cell(otp_port_pkg::OP_VERIFY, mem[i]);
      ctl(opw(otp_port_pkg::OP_PROGRAM, 1'b1));
      ctl(32'h4);
    end
    ctl(32'h2);
    for (i = 0; i < 4; i++) begin
      rd_cell(otp_port_pkg::OP_READ, mem[i]);
      `CHK(read_byte, mem[i])
      ctl(32'h4);
    end
    axi_rd(32'h10);
    `CHK(r, 32'h0)
    tgl();
    `CHK(c, 4)
    ctl(opw(otp_port_pkg::OP_PROTECT, 1'b0));
    `CHK(read_protected, 1'b1)
    `CHK(low_noise_mode, 1'b0)
    ctl(32'h2);
    rd_cell(otp_port_pkg::OP_READ, exp_byte(1'b1, mem[0]));
    ctl(opw(otp_port_pkg::OP_LOW_NOISE, 1'b0));
    `CHK(low_noise_mode, 1'b1)
    tgl();
    `CHK(c, 8)
    ctl(opw(otp_port_pkg::OP_LATCH_OFF, 1'b0));
    `CHK(latch_disable, 1'b1)
    ctl(opw(otp_port_pkg::OP_WDT_PERM, 1'b0));
    `CHK(wdt_permanent, 1'b1)
    `CHK(wdt_stoppable, 1'b0)
    ctl(opw(otp_port_pkg::OP_LOCKOUT, 1'b0));
    // power cycle: lockout only takes hold once reset samples it
    nrst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(prog_locked, 1'b1)
    `CHK(wdt_permanent, 1'b1)
    `CHK(wdt_stoppable, 1'b0)
    rd_cell(otp_port_pkg::OP_VERIFY, 8'hff);
    end_sim();
  end
endmodule
